/* verilog/gpc_pkg.sv */
`default_nettype none
package gpc_pkg;
  // ************************************************************
  // bus layout
  // ************************************************************
  localparam int GPC_ADDR_W = 4;
  localparam int GPC_WORD_W = 32;
  localparam int GPC_IDX_LSB = 2;
  localparam int GPC_IDX_W = 2;
  localparam logic [1:0] GPC_ALIGN_OK = 2'h0;
  localparam logic [GPC_IDX_W-1:0] GPC_IDX_DATA = 2'h0;
  localparam logic [GPC_IDX_W-1:0] GPC_IDX_DIR = 2'h1;
  localparam logic [GPC_IDX_W-1:0] GPC_IDX_OPT = 2'h2;
  localparam logic [GPC_IDX_W-1:0] GPC_IDX_SENS = 2'h3;
  localparam int GPC_LANE0 = 0;

  // ************************************************************
  // reset values and fields
  // ************************************************************
  localparam logic GPC_RST_BIT = 1'b0;
  localparam int GPC_NUM_GROUPS = 2;
  localparam int GPC_SENS_W = 2;
  localparam int GPC_SENS_REG_W = GPC_NUM_GROUPS * GPC_SENS_W;

  // ************************************************************
  // interrupt sensitivity codes
  // ************************************************************
  localparam logic [GPC_SENS_W-1:0] GPC_SENS_FALL_LOW = 2'h0;
  localparam logic [GPC_SENS_W-1:0] GPC_SENS_RISE = 2'h1;
  localparam logic [GPC_SENS_W-1:0] GPC_SENS_FALL = 2'h2;
  localparam logic [GPC_SENS_W-1:0] GPC_SENS_BOTH = 2'h3;

  // ************************************************************
  // bus slave states
  // ************************************************************
  typedef enum logic [1:0] {
    GPC_BUS_IDLE = 2'b01,
    GPC_BUS_ACK = 2'b10
  } gpc_bus_state_t;
endpackage
`default_nettype wire

/* verilog/gpc_port.sv */
// How it works
// (R1) Up to eight pins; bit X of every register serves pin X only. The sensitivity register instead holds two bits per group.
// (R2) Data and direction always present; option register a build parameter.
// (R3) Direction 0 makes an input; data reads return the synced pin level.
// (R4) Data writes on input pins only update the latch, pin unchanged.
// (R5) Direction 1 drives the latch onto the pin; reads return the latch.
// (R6) Input: option 0 floating, option 1 pull-up or interrupt input.
// (R7) Output: option 0 open-drain, option 1 push-pull.
// (R8) Interrupt inputs raise requests with the group's programmed sensitivity.
// (R9) Enabled pins of one group are ANDed; one low pin masks others.
// (R10) Output pins never produce interrupt requests.
// (R11) Peripheral claim overrides data, direction and option settings.
// (R12) Peripheral output forces output mode, push-pull or open-drain.
// (R13) Peripheral input pins need input mode; level still readable.
// (R14) Software keeps shared peripheral pins floating, not pulled up.
// (R15) Software never claims a pin set as interrupt input.
// (R16) Software writes data before switching a pin to output.
// (R17) Software follows safe mode transitions on interrupt pins.
// (R18) Reset clears data, direction and option registers.
// (R19) Option bits of absent pins read 1, also at reset.
// (R20) Sensitivity: falling and low, rising, falling, or both edges.
// (R21) Pin levels pass a two-stage synchroniser before any use.
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module gpc_port #(
  parameter int NUM_PINS = 8,
  parameter bit HAS_OPT = 1'b1,
  parameter logic [NUM_PINS-1:0] PRESENT_MASK = {NUM_PINS{1'b1}},
  parameter logic [NUM_PINS-1:0] PULLUP_MASK = {NUM_PINS{1'b1}},
  parameter logic [NUM_PINS-1:0] IRQ_MASK = {NUM_PINS{1'b1}},
  parameter logic [gpc_pkg::GPC_NUM_GROUPS-1:0][NUM_PINS-1:0] GROUP_MASK =
    {{(NUM_PINS/2){1'b1}}, {(NUM_PINS-NUM_PINS/2){1'b0}},
     {(NUM_PINS/2){1'b0}}, {(NUM_PINS-NUM_PINS/2){1'b1}}}
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [gpc_pkg::GPC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [gpc_pkg::GPC_WORD_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [gpc_pkg::GPC_WORD_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic cpu_int_masked_i,
  input wire logic [NUM_PINS-1:0] pin_i,
  output logic [NUM_PINS-1:0] pin_o,
  output logic [NUM_PINS-1:0] pin_oe_o,
  output logic [NUM_PINS-1:0] pin_pu_o,
  input wire logic [NUM_PINS-1:0] alt_en_i,
  input wire logic [NUM_PINS-1:0] alt_oe_i,
  input wire logic [NUM_PINS-1:0] alt_out_i,
  input wire logic [NUM_PINS-1:0] alt_od_i,
  output logic [NUM_PINS-1:0] alt_in_o,
  output logic [gpc_pkg::GPC_NUM_GROUPS-1:0] ext_irq_o
);
  // ************************************************************
  // bus slave
  // ************************************************************
  gpc_pkg::gpc_bus_state_t bus_state, next_bus_state;
  logic req, aligned, wr_take;
  logic [gpc_pkg::GPC_IDX_W-1:0] idx;
  logic [NUM_PINS-1:0] data_latch, dir, opt_q, opt_eff, opt_rd, data_rd;
  logic [gpc_pkg::GPC_SENS_REG_W-1:0] sens;
  logic [NUM_PINS-1:0] pin_meta, pin_sync, irq_en;
  logic [gpc_pkg::GPC_WORD_W-1:0] rd_word;

  assign req = avs_read_i | avs_write_i;
  assign aligned = (avs_address_i[1:0] == gpc_pkg::GPC_ALIGN_OK);
  assign idx = avs_address_i[gpc_pkg::GPC_IDX_LSB +: gpc_pkg::GPC_IDX_W];
  assign avs_waitrequest_o = req & (bus_state != gpc_pkg::GPC_BUS_ACK);
  assign wr_take = avs_write_i & (bus_state == gpc_pkg::GPC_BUS_ACK) &
                   avs_byteenable_i[gpc_pkg::GPC_LANE0] & aligned;

  always_comb begin
    next_bus_state = bus_state;
    unique case (bus_state)
      gpc_pkg::GPC_BUS_IDLE: begin
        if (req) begin
          next_bus_state = gpc_pkg::GPC_BUS_ACK;
        end
      end
      gpc_pkg::GPC_BUS_ACK: begin
        next_bus_state = gpc_pkg::GPC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus_state <= gpc_pkg::GPC_BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // ************************************************************
  // port registers
  // ************************************************************
  // (R18) cleared at reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      data_latch <= {NUM_PINS{gpc_pkg::GPC_RST_BIT}};
    end else if (wr_take && idx == gpc_pkg::GPC_IDX_DATA) begin
      // (R4) latch always written
      data_latch <= avs_writedata_i[NUM_PINS-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dir <= {NUM_PINS{gpc_pkg::GPC_RST_BIT}};
    end else if (wr_take && idx == gpc_pkg::GPC_IDX_DIR) begin
      dir <= avs_writedata_i[NUM_PINS-1:0];
    end
  end

  // (R19) absent pins forced high
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      opt_q <= {NUM_PINS{gpc_pkg::GPC_RST_BIT}} | ~PRESENT_MASK;
    end else if (wr_take && idx == gpc_pkg::GPC_IDX_OPT) begin
      opt_q <= avs_writedata_i[NUM_PINS-1:0] | ~PRESENT_MASK;
    end
  end

  // sensitivity only changes while cpu interrupts are masked
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sens <= {gpc_pkg::GPC_SENS_REG_W{gpc_pkg::GPC_RST_BIT}};
    end else if (wr_take && idx == gpc_pkg::GPC_IDX_SENS &&
                 cpu_int_masked_i) begin
      sens <= avs_writedata_i[gpc_pkg::GPC_SENS_REG_W-1:0];
    end
  end

  // (R2) option register optional
  // absent pins read 1 but act as option 0: floating input or open-drain output
  assign opt_eff = HAS_OPT ? (opt_q & PRESENT_MASK) : {NUM_PINS{1'b0}};
  assign opt_rd = HAS_OPT ? opt_q : {NUM_PINS{1'b0}};
  // (R3) input reads pin, (R5) output reads latch
  assign data_rd = (dir & data_latch) | (~dir & pin_sync);

  always_comb begin
    rd_word = {gpc_pkg::GPC_WORD_W{1'b0}};
    if (aligned) begin
      unique case (idx)
        gpc_pkg::GPC_IDX_DATA: rd_word[NUM_PINS-1:0] = data_rd;
        gpc_pkg::GPC_IDX_DIR: rd_word[NUM_PINS-1:0] = dir;
        gpc_pkg::GPC_IDX_OPT: rd_word[NUM_PINS-1:0] = opt_rd;
        gpc_pkg::GPC_IDX_SENS: rd_word[gpc_pkg::GPC_SENS_REG_W-1:0] = sens;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= {gpc_pkg::GPC_WORD_W{1'b0}};
    end else if (avs_read_i && bus_state == gpc_pkg::GPC_BUS_IDLE) begin
      avs_readdata_o <= rd_word;
    end
  end

  // ************************************************************
  // pin synchroniser
  // ************************************************************
  // (R21) two stages
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_meta <= {NUM_PINS{1'b0}};
      pin_sync <= {NUM_PINS{1'b0}};
    end else begin
      pin_meta <= pin_i;
      pin_sync <= pin_meta;
    end
  end

  // (R13) peripheral sees the pin level
  assign alt_in_o = pin_sync;

  // ************************************************************
  // per-pin drivers
  // ************************************************************
  // (R1) one slice per pin
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    logic drive, push_pull, value;
    always_comb begin
      drive = 1'b0;
      push_pull = 1'b0;
      value = 1'b0;
      pin_pu_o[i] = 1'b0;
      // (R11) peripheral overrides, (R12) forced output
      if (alt_en_i[i] && alt_oe_i[i]) begin
        drive = 1'b1;
        push_pull = ~alt_od_i[i];
        value = alt_out_i[i];
      end else if (alt_en_i[i]) begin
        drive = 1'b0;
      end else if (dir[i]) begin
        // (R7) option picks drive style
        drive = 1'b1;
        push_pull = opt_eff[i];
        value = data_latch[i];
      end else begin
        // (R6) pull-up where present
        pin_pu_o[i] = opt_eff[i] & PULLUP_MASK[i];
      end
    end
    assign pin_o[i] = push_pull & value;
    assign pin_oe_o[i] = drive & (push_pull | ~value);
  end

  // (R10) output pins excluded, (R6) option 1 on capable pins
  assign irq_en = IRQ_MASK & ~dir & opt_eff & ~alt_en_i;

  // ************************************************************
  // interrupt groups
  // ************************************************************
  logic [gpc_pkg::GPC_NUM_GROUPS-1:0] grp_lvl, grp_prev, grp_any, next_irq;

  for (genvar g = 0; g < gpc_pkg::GPC_NUM_GROUPS; g++) begin : g_grp
    logic [NUM_PINS-1:0] en;
    logic [gpc_pkg::GPC_SENS_W-1:0] mode;
    assign en = irq_en & GROUP_MASK[g];
    assign mode = sens[g*gpc_pkg::GPC_SENS_W +: gpc_pkg::GPC_SENS_W];
    assign grp_any[g] = |en;
    // (R9) enabled pins ANDed
    assign grp_lvl[g] = &(pin_sync | ~en);
    // (R8) (R20) sensitivity decode
    always_comb begin
      next_irq[g] = 1'b0;
      unique case (mode)
        gpc_pkg::GPC_SENS_FALL_LOW: next_irq[g] = ~grp_lvl[g];
        gpc_pkg::GPC_SENS_RISE: next_irq[g] = grp_lvl[g] & ~grp_prev[g];
        gpc_pkg::GPC_SENS_FALL: next_irq[g] = ~grp_lvl[g] & grp_prev[g];
        gpc_pkg::GPC_SENS_BOTH: next_irq[g] = grp_lvl[g] ^ grp_prev[g];
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      grp_prev <= {gpc_pkg::GPC_NUM_GROUPS{1'b1}};
      ext_irq_o <= {gpc_pkg::GPC_NUM_GROUPS{1'b0}};
    end else begin
      grp_prev <= grp_lvl;
      ext_irq_o <= next_irq & grp_any;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_sync;
    !$past(rst_i) && !$past(rst_i, 2) |-> pin_sync == $past(pin_i, 2);
  endproperty
  a_sync: assert property (p_sync) // (R21)
    else $error("pin sync not two stages");

  property p_rd_in;
    (avs_read_i && bus_state == gpc_pkg::GPC_BUS_IDLE && aligned &&
     idx == gpc_pkg::GPC_IDX_DATA)
    |=> ((avs_readdata_o[NUM_PINS-1:0] ^ $past(pin_sync)) & ~$past(dir)) == '0;
  endproperty
  a_rd_in: assert property (p_rd_in) // (R3)
    else $error("input read not pin level");

  property p_in_quiet;
    (pin_oe_o & ~dir & ~alt_en_i) == '0;
  endproperty
  a_in_quiet: assert property (p_in_quiet) // (R4)
    else $error("input pin driven");

  property p_pp;
    ((dir & opt_eff & ~alt_en_i) & ~(pin_oe_o & ~(pin_o ^ data_latch))) == '0;
  endproperty
  a_pp: assert property (p_pp) // (R5)
    else $error("push-pull not driving latch");

  property p_od;
    ((dir & ~opt_eff & ~alt_en_i) & (pin_o | (pin_oe_o ^ ~data_latch))) == '0;
  endproperty
  a_od: assert property (p_od) // (R7)
    else $error("open-drain drive wrong");

  property p_no_out_irq;
    (irq_en & dir) == '0;
  endproperty
  a_no_out_irq: assert property (p_no_out_irq) // (R10)
    else $error("output pin enabled as interrupt");

  property p_and;
    (|(GROUP_MASK[0] & irq_en & ~pin_sync)) |-> !grp_lvl[0];
  endproperty
  a_and: assert property (p_and) // (R9)
    else $error("low pin not masking group");

  property p_rise;
    (sens[1:0] == gpc_pkg::GPC_SENS_RISE && grp_any[0])
    |=> ext_irq_o[0] == ($past(grp_lvl[0]) && !$past(grp_prev[0]));
  endproperty
  a_rise: assert property (p_rise) // (R20)
    else $error("rising edge request wrong");

  property p_low;
    (sens[1:0] == gpc_pkg::GPC_SENS_FALL_LOW && !grp_lvl[0])
    |=> ext_irq_o[0];
  endproperty
  a_low: assert property (p_low) // (R8)
    else $error("low level request missing");

  property p_alt_out;
    (alt_en_i[0] && alt_oe_i[0] && !alt_od_i[0]) |-> pin_oe_o[0] &&
    pin_o[0] == alt_out_i[0];
  endproperty
  a_alt_out: assert property (p_alt_out) // (R12)
    else $error("peripheral output not forced");

  property p_absent;
    HAS_OPT |-> (~opt_rd & ~PRESENT_MASK) == '0;
  endproperty
  a_absent: assert property (p_absent) // (R19)
    else $error("absent option bit not one");

  property p_reset;
    rst_i |=> data_latch == '0 && dir == '0;
  endproperty
  a_reset: assert property (disable iff (1'b0) p_reset) // (R18)
    else $error("registers not cleared by reset");

  c_write: cover property (wr_take && idx == gpc_pkg::GPC_IDX_DIR);
  c_irq: cover property (ext_irq_o[0]);
  c_alt: cover property (alt_en_i[0] && alt_oe_i[0]);
  c_od: cover property (dir[0] && !opt_eff[0] && !data_latch[0]);
endmodule
`default_nettype wire

/* verification/gpc_board.sv */
`timescale 1ns/1ps
`default_nettype none
module gpc_board (
  input wire logic ref_clk_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pin_pu_o,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pin_lvl_o
);
  // ****************************************
  // pad level resolution
  // ****************************************
  logic [7:0] float_pat = 8'h55;

  // undriven lines wander each cycle
  always @(posedge ref_clk_i) begin
    float_pat <= ~float_pat;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_o[i]) pin_lvl_o[i] = pin_o[i];
      else if (ext_en_i[i]) pin_lvl_o[i] = ext_val_i[i];
      else if (pin_pu_o[i]) pin_lvl_o[i] = 1'b1;
      else pin_lvl_o[i] = float_pat[i];
    end
  end
endmodule
`default_nettype wire

/* verification/gpio_port_pin_config_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_port_pin_config_bench;
  localparam logic [7:0] PRES = 8'h7F;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic cpu_int_masked_i = 1'b1;
  logic [7:0] pin_i, pin_o, pin_oe_o, pin_pu_o, alt_in_o;
  logic [7:0] alt_en_i = 8'h00, alt_oe_i = 8'h00;
  logic [7:0] alt_od_i = 8'h00, alt_out_i = 8'h00;
  logic [7:0] ext_val = 8'hA5;
  logic [1:0] ext_irq_o;
  int fails = 0, n_tests = 0, cnt0 = 0, cnt1 = 0;
  int seed = 32'h297e;

  always #25 ref_clk_i = ~ref_clk_i;
  always @(negedge ref_clk_i) begin
    cnt0 += (ext_irq_o[0] !== 1'b0);
    cnt1 += (ext_irq_o[1] !== 1'b0);
  end

  gpc_port #(.PRESENT_MASK(PRES)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .cpu_int_masked_i(cpu_int_masked_i), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pin_pu_o(pin_pu_o), .alt_en_i(alt_en_i),
    .alt_oe_i(alt_oe_i), .alt_out_i(alt_out_i), .alt_od_i(alt_od_i),
    .alt_in_o(alt_in_o), .ext_irq_o(ext_irq_o));
  gpc_board board (.ref_clk_i(ref_clk_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pin_pu_o(pin_pu_o), .ext_en_i(8'hFF),
    .ext_val_i(ext_val), .pin_lvl_o(pin_i));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      fails++;
      wrap_up();
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input string nm, input logic [3:0] a,
                       input logic [31:0] msk, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q & msk, exp & msk);
  endtask
  task automatic pulse(input logic [7:0] v, output int a, output int b);
    @(posedge ref_clk_i);
    ext_val <= v;
    cnt0 = 0;
    cnt1 = 0;
    tick(8);
    a = cnt0;
    b = cnt1;
  endtask
  function automatic logic [7:0] e_oe(input logic [7:0] d, dr, op, ae, ao,
                                      ad, av);
    return (ae & ao & ~(ad & av)) | (~ae & dr & (op | ~d));
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] d, dr, op, ae, ao, ad, av, ev, oe, lv;
    int f0, f1, r0, r1;
    tick(20);
    rst_i <= 1'b0;
    tick(2);
    rdchk("data_in", 4'h0, PRES, 32'hA5);
    rdchk("dir_rst", 4'h4, 32'hFF, 32'h0);
    rdchk("opt_rst", 4'h8, 32'hFF, 32'h80);
    rdchk("sens_rst", 4'hC, 32'hF, 32'h0);
    avs_byteenable_i <= 4'h0;
    wr(4'h4, 32'hFF);
    avs_byteenable_i <= 4'hF;
    wr(4'h5, 32'hFF);
    cpu_int_masked_i <= 1'b0;
    wr(4'hC, 32'hF);
    cpu_int_masked_i <= 1'b1;
    rdchk("dir_refused", 4'h4, 32'hFF, 32'h0);
    rdchk("sens_refused", 4'hC, 32'hF, 32'h0);
    rdchk("unaligned_rd", 4'h1, 32'hFFFFFFFF, 32'h0);
    $display("test reset and refusals done");
    for (int i = 0; i < 40; i++) begin
      {d, dr, ae, ao} = $random(seed);
      {ad, av, ev} = 24'($random(seed));
      op = 8'($random(seed)) & ~(ae & ~dr);
      @(posedge ref_clk_i);
      alt_en_i <= ae;
      alt_oe_i <= ao;
      alt_od_i <= ad;
      alt_out_i <= av;
      ext_val <= ev;
      wr(4'h0, {24'h0, d});
      wr(4'h8, {24'h0, op});
      wr(4'h4, {24'h0, dr});
      tick(3);
      oe = e_oe(d, dr, op | ~PRES, ae, ao, ad, av);
      lv = (oe & ((ae & av) | (~ae & d))) | (~oe & ev);
      chk("oe", pin_oe_o & PRES, oe & PRES);
      chk("out", pin_o & oe & PRES, ((ae & av) | (~ae & d)) & oe & PRES);
      chk("pullup", pin_pu_o & PRES, ~ae & ~dr & op & PRES);
      chk("alt_in", alt_in_o & PRES, lv & PRES);
      rdchk("data_rd", 4'h0, PRES, (dr & d) | (~dr & lv));
      rdchk("opt_rd", 4'h8, 32'hFF, op | 8'h80);
      rdchk("dir_rd", 4'h4, 32'hFF, dr);
    end
    $display("test random modes done");
    @(posedge ref_clk_i);
    alt_en_i <= 8'h00;
    ext_val <= 8'h7F;
    wr(4'h4, 32'h0);
    wr(4'h8, 32'h11);
    for (int m = 0; m < 4; m++) begin
      wr(4'hC, {28'h0, 2'(m), 2'(m)});
      tick(6);
      // absent pin 7 held low must not mask group 1
      pulse(8'h6E, f0, f1);
      pulse(8'h7F, r0, r1);
      chk("fall0", (m == 0) ? 32'(f0 != 0) : 32'(f0), 32'(m != 1));
      chk("fall1", (m == 0) ? 32'(f1 != 0) : 32'(f1), 32'(m != 1));
      if (m != 0) chk("rise0", r0, 32'(m % 2));
      if (m != 0) chk("rise1", r1, 32'(m % 2));
    end
    wr(4'hC, 32'hA);
    pulse(8'hFD, f0, f1);
    wr(4'h8, 32'h03);
    tick(6);
    pulse(8'hFC, f0, f1);
    pulse(8'hFD, r0, r1);
    chk("irq_and", f0 + r0, 32'h0);
    wr(4'hC, 32'hF);
    wr(4'h0, 32'h01);
    wr(4'h4, 32'h01);
    wr(4'h8, 32'h01);
    tick(6);
    cnt0 = 0;
    wr(4'h0, 32'h0);
    tick(6);
    wr(4'h0, 32'h1);
    tick(6);
    chk("irq_out", cnt0, 32'h0);
    $display("test interrupts done");
    wrap_up();
  end

  initial begin
    #2000000;
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
